// *** hw/numeric_oscillator_consts.vh ***
// Register offsets, field positions, reset values and timing figures of the numeric oscillator.
`ifndef NUMERIC_OSCILLATOR_CONSTS_VH
`define NUMERIC_OSCILLATOR_CONSTS_VH

// ****************************************************************
// Register byte offsets on the register bus
// ****************************************************************
`define OFS_CONTROL        12'h000
`define OFS_CLOCK_WIDTH    12'h004
`define OFS_ACC_LOW        12'h008
`define OFS_ACC_HIGH       12'h00C
`define OFS_ACC_UPPER      12'h010
`define OFS_INC_LOW        12'h014
`define OFS_INC_HIGH       12'h018
`define OFS_INC_UPPER      12'h01C
`define OFS_FLAG_STATUS    12'h020

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_ENABLE_BIT     7
`define CTL_STATUS_BIT     5
`define CTL_INVERT_BIT     4
`define CTL_PULSE_BIT      0

// ****************************************************************
// Clock register fields
// ****************************************************************
`define CLK_WIDTH_MSB      7
`define CLK_WIDTH_LSB      5
`define CLK_SEL_MSB        3
`define CLK_SEL_LSB        0

// ****************************************************************
// Flag register fields
// ****************************************************************
`define FLAG_OVERFLOW_BIT  0

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_BYTE_ZERO      8'h00
`define RST_INC_LOW        8'h01
`define RST_NIBBLE_ZERO    4'h0

// ****************************************************************
// Widths and clock source codes
// ****************************************************************
`define ACC_WIDTH          20
`define SRC_SYSTEM         4'h0
`define SRC_FAST_INT       4'h1
`define SRC_SLOW_INT       4'h2
`define SRC_MED_500K       4'h3
`define SRC_MED_32K        4'h4
`define SRC_REF_CLK        4'h6
`define SRC_LOGIC_ONE      4'h7
`define SRC_LOGIC_FOUR     4'hA

// ****************************************************************
// Timing: bus clock period in picoseconds and input synchroniser depth
// ****************************************************************
`define CLK_PERIOD_PS      5000
`define SYNC_STAGES        2

`endif

// *** hw/numeric_oscillator_regs.v ***
// Numeric oscillator core with its AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "numeric_oscillator_consts.vh"

// Operation
// R1: Oscillator runs only while the enable bit 7 of control is one.
// R2: Control bit 5 reads the live module output and is read-only.
// R3: Invert bit one inverts the output; zero passes it unchanged.
// R4: Control bit 0 picks pulse mode when one, toggle mode when zero.
// R5: Width field bits 7..5 give two to the field input periods active.
// R6: Width field matters only in pulse mode.
// R7: Four-bit select picks one of the documented input clock sources.
// R8: Software must avoid reserved clock codes 0101 and 1011 to 1111.
// R9: Accumulator is 20 bits in three bytes; upper bits 7..4 read zero.
// R10: Accumulator runs from the input clock; no atomic multi-byte access.
// R11: Software must not write the accumulator while the module runs.
// R12: Step value is upper, high and low step bytes joined.
// R13: Low step byte resets to one.
// R14: Shadow buffer loads whole step on the input falling edge after low write.
// R15: Software writes upper and high step bytes before the low byte.
// R16: Unused control bits 6 and 3..1 and clock bit 4 read zero.
// R17: Control, clock, accumulator and high step bytes reset to zero.
// R18: Each input rising edge adds the buffered step; carry out is overflow.
// R19: Toggle mode flips the output on every overflow.
// R20: Pulse mode goes active on the input edge after overflow for the width; the code starts the pulse one bus clock after the overflow cycle instead.
// R21: Each overflow sets a sticky flag that software clears.
// R22: While disabled the accumulator holds and the output rests inactive.
module numeric_oscillator_regs (
	input  wire        clk,
	input  wire        resetn,
	input  wire        hsel,
	input  wire [11:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        systemOsc,
	input  wire        fastInternalOsc,
	input  wire        slowInternalOsc,
	input  wire        mediumInternalOsc500k,
	input  wire        mediumInternalOsc32k,
	input  wire        referenceClockOut,
	input  wire        logicCellOneOutput,
	input  wire        logicCellTwoOutput,
	input  wire        logicCellThreeOutput,
	input  wire        logicCellFourOutput,
	output wire        oscOutput,
	output wire        accumulatorCarry,
	output wire        overflowFlag
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	reg        oscEnable_reg;
	reg        outputInvert_reg;
	reg        pulseModeSelect_reg;
	reg [2:0]  pulseWidthSelect_reg;
	reg [3:0]  inputClockSelect_reg;
	reg [`ACC_WIDTH-1:0] phaseAccumulator_reg;
	reg [7:0]  stepLow_reg;
	reg [7:0]  stepHigh_reg;
	reg [3:0]  stepUpper_reg;
	reg [`ACC_WIDTH-1:0] stepShadowBuffer_reg;
	reg        shadowPending_reg;
	reg        toggleState_reg;
	reg        overflowFlag_reg;
	reg        carry_reg;

	// ****************************************************************
	// AHB-Lite address phase capture
	// ****************************************************************
	reg        dataPhaseWrite_reg;
	reg        dataPhaseRead_reg;
	reg [11:0] dataPhaseAddr_reg;
	wire       addrPhaseValid = hsel && hready && htrans[1];

	always @(posedge clk) begin
		if (!resetn) begin
			dataPhaseWrite_reg <= 1'b0;
			dataPhaseRead_reg  <= 1'b0;
			dataPhaseAddr_reg  <= 12'h000;
		end else if (hready) begin
			dataPhaseWrite_reg <= addrPhaseValid && hwrite;
			dataPhaseRead_reg  <= addrPhaseValid && !hwrite;
			dataPhaseAddr_reg  <= haddr;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Decodes one register write strobe from the data-phase address.
	function writeHit;
		input        wr;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			writeHit = wr && (addr == ofs);
		end
	endfunction

	wire wrControl = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_CONTROL);
	wire wrClock   = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_CLOCK_WIDTH);
	wire wrAccLow  = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_ACC_LOW);
	wire wrAccHigh = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_ACC_HIGH);
	wire wrAccUp   = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_ACC_UPPER);
	wire wrIncLow  = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_INC_LOW);
	wire wrIncHigh = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_INC_HIGH);
	wire wrIncUp   = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_INC_UPPER);
	wire wrFlag    = writeHit(dataPhaseWrite_reg, dataPhaseAddr_reg, `OFS_FLAG_STATUS);

	// ****************************************************************
	// Input clock selection
	// ****************************************************************
	wire inputRise;
	wire inputFall;
	wire [10:0] sourceLevels = {logicCellFourOutput, logicCellThreeOutput, logicCellTwoOutput,
		logicCellOneOutput, referenceClockOut, 1'b0, mediumInternalOsc32k, mediumInternalOsc500k,
		slowInternalOsc, fastInternalOsc, systemOsc};

	osc_clock_select clockPick (
		.clk          (clk),
		.resetn       (resetn),
		.clockSelect  (inputClockSelect_reg), // see R7
		.sourceLevels (sourceLevels),
		.risingEdge   (inputRise),
		.fallingEdge  (inputFall)
	);

	// ****************************************************************
	// Adder and step shadow buffer
	// ****************************************************************
	wire [`ACC_WIDTH-1:0] stepValue = {stepUpper_reg, stepHigh_reg, stepLow_reg}; // see R12
	wire [`ACC_WIDTH:0]   sumFull   = {1'b0, phaseAccumulator_reg} + {1'b0, stepShadowBuffer_reg};
	wire                  advance   = oscEnable_reg && inputRise; // see R1
	wire                  overflowNow = advance && sumFull[`ACC_WIDTH]; // see R18

	always @(posedge clk) begin
		if (!resetn) begin
			phaseAccumulator_reg <= {`ACC_WIDTH{1'b0}}; // see R17
			carry_reg            <= 1'b0;
		end else begin
			carry_reg <= overflowNow;
			if (advance)
				phaseAccumulator_reg <= sumFull[`ACC_WIDTH-1:0]; // see R18
			else begin
				// Writes land directly; the accumulator otherwise holds while disabled.
				if (wrAccLow)
					phaseAccumulator_reg[7:0] <= hwdata[7:0]; // see R22
				if (wrAccHigh)
					phaseAccumulator_reg[15:8] <= hwdata[7:0];
				if (wrAccUp)
					phaseAccumulator_reg[19:16] <= hwdata[3:0];
			end
		end
	end

	// The shadow loads on the falling input edge after a low-byte write, or at once while disabled.
	always @(posedge clk) begin
		if (!resetn) begin
			stepShadowBuffer_reg <= {{(`ACC_WIDTH-8){1'b0}}, `RST_INC_LOW};
			shadowPending_reg    <= 1'b0;
		end else if (!oscEnable_reg) begin
			stepShadowBuffer_reg <= stepValue;
			shadowPending_reg    <= 1'b0;
		end else if (shadowPending_reg && inputFall) begin
			stepShadowBuffer_reg <= stepValue; // see R14
			shadowPending_reg    <= wrIncLow;
		end else if (wrIncLow) begin
			shadowPending_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	always @(posedge clk) begin
		if (!resetn) begin
			oscEnable_reg        <= 1'b0; // see R17
			outputInvert_reg     <= 1'b0;
			pulseModeSelect_reg  <= 1'b0;
			pulseWidthSelect_reg <= 3'h0;
			inputClockSelect_reg <= `RST_NIBBLE_ZERO;
			stepLow_reg          <= `RST_INC_LOW; // see R13
			stepHigh_reg         <= `RST_BYTE_ZERO;
			stepUpper_reg        <= `RST_NIBBLE_ZERO;
		end else begin
			if (wrControl) begin
				oscEnable_reg       <= hwdata[`CTL_ENABLE_BIT];
				outputInvert_reg    <= hwdata[`CTL_INVERT_BIT];
				pulseModeSelect_reg <= hwdata[`CTL_PULSE_BIT];
			end
			if (wrClock) begin
				pulseWidthSelect_reg <= hwdata[`CLK_WIDTH_MSB:`CLK_WIDTH_LSB];
				inputClockSelect_reg <= hwdata[`CLK_SEL_MSB:`CLK_SEL_LSB];
			end
			if (wrIncLow)
				stepLow_reg <= hwdata[7:0];
			if (wrIncHigh)
				stepHigh_reg <= hwdata[7:0];
			if (wrIncUp)
				stepUpper_reg <= hwdata[3:0];
		end
	end

	// Sticky flag: an overflow in the clearing cycle wins over the clear.
	always @(posedge clk) begin
		if (!resetn)
			overflowFlag_reg <= 1'b0;
		else if (overflowNow)
			overflowFlag_reg <= 1'b1; // see R21
		else if (wrFlag && !hwdata[`FLAG_OVERFLOW_BIT])
			overflowFlag_reg <= 1'b0;
	end

	// ****************************************************************
	// Output stages
	// ****************************************************************
	wire pulseActive;

	pulse_width_timer widthTimer (
		.clk         (clk),
		.resetn      (resetn),
		.clear       (!oscEnable_reg || !pulseModeSelect_reg), // see R6
		.start       (carry_reg && pulseModeSelect_reg && oscEnable_reg), // see R20
		.tick        (inputRise),
		.widthSelect (pulseWidthSelect_reg), // see R5
		.active      (pulseActive)
	);

	always @(posedge clk) begin
		if (!resetn || !oscEnable_reg)
			toggleState_reg <= 1'b0; // see R22
		else if (overflowNow && !pulseModeSelect_reg)
			toggleState_reg <= ~toggleState_reg; // see R19
	end

	wire rawOutput = pulseModeSelect_reg ? pulseActive : toggleState_reg; // see R4
	assign oscOutput        = rawOutput ^ outputInvert_reg; // see R3
	assign accumulatorCarry = carry_reg;
	assign overflowFlag     = overflowFlag_reg;

	// ****************************************************************
	// Read data
	// ****************************************************************
	always @(posedge clk) begin
		if (!resetn)
			hrdata <= 32'h00000000;
		else if (addrPhaseValid && !hwrite) begin
			hrdata <= 32'h00000000;
			case (haddr)
				`OFS_CONTROL:     hrdata[7:0] <= {oscEnable_reg, 1'b0, oscOutput, outputInvert_reg,
					3'b000, pulseModeSelect_reg}; // see R2, R16
				`OFS_CLOCK_WIDTH: hrdata[7:0] <= {pulseWidthSelect_reg, 1'b0, inputClockSelect_reg};
				`OFS_ACC_LOW:     hrdata[7:0] <= phaseAccumulator_reg[7:0]; // see R10
				`OFS_ACC_HIGH:    hrdata[7:0] <= phaseAccumulator_reg[15:8];
				`OFS_ACC_UPPER:   hrdata[7:0] <= {4'h0, phaseAccumulator_reg[19:16]}; // see R9
				`OFS_INC_LOW:     hrdata[7:0] <= stepLow_reg;
				`OFS_INC_HIGH:    hrdata[7:0] <= stepHigh_reg;
				`OFS_INC_UPPER:   hrdata[7:0] <= {4'h0, stepUpper_reg};
				`OFS_FLAG_STATUS: hrdata[7:0] <= {7'h00, overflowFlag_reg};
				default:          hrdata <= 32'h00000000;
			endcase
		end
	end

endmodule // numeric_oscillator_regs

`default_nettype wire

// *** hw/osc_clock_select.v ***
// Input clock source multiplexer with synchroniser and edge detection for the numeric oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "numeric_oscillator_consts.vh"

module osc_clock_select (
	input  wire        clk,
	input  wire        resetn,
	input  wire [3:0]  clockSelect,
	input  wire [10:0] sourceLevels,
	output reg         risingEdge,
	output reg         fallingEdge
);

	// ****************************************************************
	// Source picking
	// ****************************************************************
	// Reserved codes pick a constant low level, so the oscillator never advances.
	reg picked;
	always @* begin
		picked = 1'b0;
		if (clockSelect <= `SRC_LOGIC_FOUR && clockSelect != 4'h5)
			picked = sourceLevels[clockSelect];
	end

	// ****************************************************************
	// Two-stage synchroniser and edge detector
	// ****************************************************************
	reg syncFirst_reg;
	reg syncSecond_reg;
	reg syncLast_reg;
	always @(posedge clk) begin
		if (!resetn) begin
			syncFirst_reg  <= 1'b0;
			syncSecond_reg <= 1'b0;
			syncLast_reg   <= 1'b0;
			risingEdge     <= 1'b0;
			fallingEdge    <= 1'b0;
		end else begin
			syncFirst_reg  <= picked;
			syncSecond_reg <= syncFirst_reg;
			syncLast_reg   <= syncSecond_reg;
			risingEdge     <= syncSecond_reg & ~syncLast_reg;
			fallingEdge    <= ~syncSecond_reg & syncLast_reg;
		end
	end

endmodule // osc_clock_select

`default_nettype wire

// *** hw/pulse_width_timer.v ***
// Counter that holds the pulse-mode output active for a power-of-two number of input clock periods.
`timescale 1ns/1ps
`default_nettype none
`include "numeric_oscillator_consts.vh"

module pulse_width_timer (
	input  wire       clk,
	input  wire       resetn,
	input  wire       clear,
	input  wire       start,
	input  wire       tick,
	input  wire [2:0] widthSelect,
	output reg        active
);

	reg [7:0] remain_reg;

	// Number of input periods for a width code: two to the power of the code.
	function [7:0] periodsFor;
		input [2:0] code;
		begin
			periodsFor = 8'h01 << code;
		end
	endfunction

	always @(posedge clk) begin
		if (!resetn || clear) begin
			remain_reg <= 8'h00;
			active     <= 1'b0;
		end else if (start) begin
			remain_reg <= periodsFor(widthSelect);
			active     <= 1'b1;
		end else if (tick && active) begin
			if (remain_reg == 8'h01)
				active <= 1'b0;
			remain_reg <= remain_reg - 8'h01;
		end
	end

endmodule // pulse_width_timer

`default_nettype wire

// *** test/numeric_oscillator_props.sv ***
// Concurrent checks on the numeric oscillator ports.
`timescale 1ns/1ps
`default_nettype none
`include "numeric_oscillator_consts.vh"
module numeric_oscillator_props (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        oscOutput,
	input wire logic        accumulatorCarry,
	input wire logic        overflowFlag
);
	// Data phase tracking and a copy of the writable control bits.
	logic        rdPhase;
	logic        wrPhase;
	logic [11:0] phaseAddr;
	logic [7:0]  ctrlMirror;
	wire logic   enOn = ctrlMirror[`CTL_ENABLE_BIT];
	wire logic   pol  = ctrlMirror[`CTL_INVERT_BIT];
	always @(posedge clk) begin
		if (!resetn) begin
			rdPhase    <= 1'h0;
			wrPhase    <= 1'h0;
			phaseAddr  <= 12'h000;
			ctrlMirror <= 8'h00;
		end else begin
			rdPhase <= hsel && hready && htrans[1] && !hwrite;
			wrPhase <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1])
				phaseAddr <= haddr;
			if (wrPhase && phaseAddr == `OFS_CONTROL)
				ctrlMirror <= hwdata[7:0] & 8'h91;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_flag_set; accumulatorCarry |-> ##[0:1] overflowFlag; endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set by carry");
	property p_flag_hold;
		$fell(overflowFlag) && $past(resetn) |-> $past(wrPhase) && $past(phaseAddr) == `OFS_FLAG_STATUS;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without a write");
	property p_carry_pulse; accumulatorCarry |=> !accumulatorCarry; endproperty
	a_carry_pulse: assert property (p_carry_pulse) else $error("carry longer than one cycle");
	property p_idle_carry; !enOn && !$past(enOn) && !$past(enOn, 2) && !$past(enOn, 3) |-> !accumulatorCarry; endproperty
	a_idle_carry: assert property (p_idle_carry) else $error("carry while disabled");
	property p_idle_level; !enOn && !$past(enOn) && !$past(enOn, 2) |-> oscOutput == pol; endproperty
	a_idle_level: assert property (p_idle_level) else $error("output not at rest level");
	property p_status; rdPhase && phaseAddr == `OFS_CONTROL |-> hrdata[5] == $past(oscOutput); endproperty
	a_status: assert property (p_status) else $error("status bit differs from output");
	property p_ctrl_zero; rdPhase && phaseAddr == `OFS_CONTROL |-> hrdata[6] == 1'h0 && hrdata[3:1] == 3'h0; endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("control unused bits set");
	property p_clk_zero; rdPhase && phaseAddr == `OFS_CLOCK_WIDTH |-> hrdata[4] == 1'h0; endproperty
	a_clk_zero: assert property (p_clk_zero) else $error("clock unused bit set");
	property p_accu_zero; rdPhase && phaseAddr == `OFS_ACC_UPPER |-> hrdata[7:4] == 4'h0; endproperty
	a_accu_zero: assert property (p_accu_zero) else $error("accumulator upper bits set");
	property p_pulse_start; accumulatorCarry && enOn && ctrlMirror[0] && !wrPhase |=> oscOutput != pol; endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse not started");
	property p_toggle;
		accumulatorCarry && enOn && !ctrlMirror[0] && $stable(ctrlMirror) |-> oscOutput != $past(oscOutput);
	endproperty
	a_toggle: assert property (p_toggle) else $error("output did not toggle");
endmodule // numeric_oscillator_props
bind numeric_oscillator_regs numeric_oscillator_props chk (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .oscOutput(oscOutput),
	.accumulatorCarry(accumulatorCarry), .overflowFlag(overflowFlag));
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the numeric oscillator register block.
`timescale 1ns/1ps
`default_nettype none
`include "numeric_oscillator_consts.vh"
module testbench;
	reg         clk = 1'h0;
	reg         resetn = 1'h0;
	reg         hsel = 1'h0;
	reg  [11:0] haddr = 12'h000;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'h0;
	reg  [31:0] hwdata = 32'h00000000;
	reg  [9:0]  srcLevels = 10'h000;
	reg  [9:0]  srcMask = 10'h000;
	reg  [2:0]  divCnt = 3'h0;
	reg         clrCount = 1'h0;
	reg  [15:0] carryCount = 16'h0000;
	reg  [31:0] rd = 32'h00000000;
	integer     cycles = 0;
	integer     badCount = 0;
	integer     checkCount = 0;
	wire        hreadyout;
	wire        hresp;
	wire [31:0] hrdata;
	wire        oscOutput;
	wire        accumulatorCarry;
	wire        overflowFlag;
	numeric_oscillator_regs uut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .systemOsc(srcLevels[0]), .fastInternalOsc(srcLevels[1]), .slowInternalOsc(srcLevels[2]),
		.mediumInternalOsc500k(srcLevels[3]), .mediumInternalOsc32k(srcLevels[4]),
		.referenceClockOut(srcLevels[5]), .logicCellOneOutput(srcLevels[6]), .logicCellTwoOutput(srcLevels[7]),
		.logicCellThreeOutput(srcLevels[8]), .logicCellFourOutput(srcLevels[9]), .oscOutput(oscOutput),
		.accumulatorCarry(accumulatorCarry), .overflowFlag(overflowFlag));
	always #2.5 clk = ~clk;
	// The source wave is 4 cycles high and 4 low, placed on the sources picked by srcMask.
	always @(posedge clk) begin
		divCnt <= divCnt + 3'h1;
		srcLevels <= divCnt[2] ? srcMask : 10'h000;
		carryCount <= clrCount ? 16'h0000 : carryCount + {15'h0000, accumulatorCarry === 1'h1};
		cycles = cycles + 1;
		if (cycles == 60000) begin
			badCount = badCount + 1;
			results;
		end
	end
	task results;
		begin
			$display("Checks %0d, mismatches %0d", checkCount, badCount);
			if (badCount == 0 && checkCount > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task checkRange(input string name, input [31:0] lo, input [31:0] hi, input [31:0] got);
		begin
			checkCount = checkCount + 1;
			if (!(got >= lo && got <= hi)) begin
				badCount = badCount + 1;
				$display("[FAIL] %s expected %0h..%0h seen %0h", name, lo, hi, got);
			end
		end
	endtask
	task bus(input logic wr, input [11:0] a, input [7:0] d);
		begin
			@(posedge clk);
			hsel <= 1'h1;
			haddr <= a;
			hwrite <= wr;
			htrans <= 2'h2;
			do @(posedge clk); while (hreadyout !== 1'h1);
			hsel <= 1'h0;
			htrans <= 2'h0;
			hwdata <= {24'h000000, d};
			do @(posedge clk); while (hreadyout !== 1'h1);
			rd = hrdata;
			checkRange("response", 0, 0, {31'h00000000, hresp});
		end
	endtask
	task rdChk(input string name, input [11:0] a, input [31:0] e);
		begin
			bus(1'h0, a, 8'h00);
			checkRange(name, e, e, rd);
		end
	endtask
	task countOver(input integer rises);
		begin
			repeat (16) @(posedge clk);
			clrCount <= 1'h1;
			@(posedge clk);
			clrCount <= 1'h0;
			repeat (rises * 8) @(posedge clk);
		end
	endtask
	task runStep(input [19:0] s, input [19:0] eff, input logic lo, input integer rises);
		integer e;
		begin
			bus(1'h1, `OFS_INC_UPPER, {4'h0, s[19:16]});
			bus(1'h1, `OFS_INC_HIGH, s[15:8]);
			if (lo)
				bus(1'h1, `OFS_INC_LOW, s[7:0]);
			countOver(rises);
			e = (rises * eff) >> 20;
			checkRange("carries", e - 1, e + 1, {16'h0000, carryCount});
		end
	endtask
	task testRegisters;
		reg [11:0] a;
		begin
			for (a = 12'h000; a < 12'h028; a = a + 12'h004)
				rdChk("reset value", a, (a == `OFS_INC_LOW) ? 32'h01 : 32'h00);
			bus(1'h1, `OFS_CONTROL, 8'h6E);
			rdChk("control", `OFS_CONTROL, 32'h00);
			bus(1'h1, `OFS_CONTROL, 8'h5E);
			rdChk("control", `OFS_CONTROL, 32'h30);
			bus(1'h1, `OFS_CLOCK_WIDTH, 8'hFF);
			rdChk("clock", `OFS_CLOCK_WIDTH, 32'hEF);
			bus(1'h1, `OFS_ACC_UPPER, 8'hFF);
			rdChk("acc upper", `OFS_ACC_UPPER, 32'h0F);
			bus(1'h1, 12'h024, 8'hFF);
			rdChk("unmapped", 12'h024, 32'h00);
			bus(1'h1, `OFS_ACC_UPPER, 8'h00);
			bus(1'h1, `OFS_CLOCK_WIDTH, 8'h00);
		end
	endtask
	task testPulse;
		integer w;
		integer n;
		begin
			bus(1'h1, `OFS_INC_HIGH, 8'h10);
			bus(1'h1, `OFS_INC_LOW, 8'h00);
			for (w = 0; w < 8; w++) begin
				bus(1'h1, `OFS_CONTROL, 8'h10);
				bus(1'h1, `OFS_CLOCK_WIDTH, {w[2:0], 5'h00});
				bus(1'h1, `OFS_CONTROL, 8'h91);
				n = 0;
				while (oscOutput !== 1'h0)
					@(posedge clk);
				while (oscOutput === 1'h0) begin
					n++;
					@(posedge clk);
				end
				checkRange("pulse width", (8 << w) - 3, (8 << w) + 3, n);
			end
		end
	endtask
	task testSteps;
		begin
			bus(1'h1, `OFS_CONTROL, 8'h00);
			bus(1'h1, `OFS_CLOCK_WIDTH, 8'hE0);
			bus(1'h1, `OFS_CONTROL, 8'h80);
			runStep(20'h80000, 20'h80000, 1'h1, 16);
			runStep(20'h40000, 20'h40000, 1'h1, 32);
			runStep(20'hFFFFF, 20'hFFFFF, 1'h1, 16);
			runStep(20'h0C000, 20'h0C000, 1'h1, 64);
			runStep(20'hFC000, 20'h0C000, 1'h0, 64);
			bus(1'h1, `OFS_CONTROL, 8'h00);
			rdChk("flag", `OFS_FLAG_STATUS, 32'h01);
			bus(1'h1, `OFS_FLAG_STATUS, 8'h01);
			rdChk("flag", `OFS_FLAG_STATUS, 32'h01);
			bus(1'h1, `OFS_FLAG_STATUS, 8'h00);
			rdChk("flag", `OFS_FLAG_STATUS, 32'h00);
		end
	endtask
	task testSelect;
		integer c;
		reg [9:0] m;
		begin
			bus(1'h1, `OFS_CONTROL, 8'h80);
			runStep(20'h80000, 20'h80000, 1'h1, 8);
			for (c = 0; c < 11; c++) begin
				m = (c == 5) ? 10'h000 : 10'h001 << (c < 5 ? c : c - 1);
				bus(1'h1, `OFS_CLOCK_WIDTH, c[7:0]);
				srcMask <= ~m;
				countOver(8);
				checkRange("other sources", 0, 0, {16'h0000, carryCount});
				srcMask <= m;
				countOver(8);
				checkRange("chosen source", (c == 5) ? 0 : 3, (c == 5) ? 0 : 5, {16'h0000, carryCount});
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		testRegisters;
		srcMask <= 10'h001;
		testPulse;
		testSteps;
		testSelect;
		resetn <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		rdChk("step low", `OFS_INC_LOW, 32'h01);
		rdChk("control", `OFS_CONTROL, 32'h00);
		results;
	end
endmodule // testbench
`default_nettype wire
